// File: rtl/dct_drive_tag.sv
// Drive-side control-tag decoder, unit select and status bus
`timescale 1ns/1ps
module dct_drive_tag
    import dct_pkg::*;
#(
    parameter int UNIT_W = 4
) (
    input  wire logic                        clk,
    input  wire logic                        rstn,
    input  wire logic [2:0]                  tag,
    input  wire logic [7:0]                  bus_out,
    input  wire logic                        select_strobe,
    input  wire logic [UNIT_W-1:0]           unit_addr,
    input  wire logic [UNIT_W-1:0]           plug_addr,
    input  wire logic                        mark_detect,
    input  wire logic                        heads_positioned,
    input  wire logic                        spindle_up,
    input  wire logic                        heads_loaded,
    input  wire logic                        fault_cond,
    input  wire logic                        servo_offset,
    input  wire logic                        seek_error_latch,
    input  wire logic                        fault_latch,
    input  wire logic                        no_head_fault,
    input  wire logic                        write_protect,
    input  wire logic                        seek_done,
    input  wire logic                        seek_ok,
    input  wire logic [dct_pkg::DCT_ADDR_W-1:0] reg_addr,
    input  wire logic [dct_pkg::DCT_DATA_W-1:0] reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic [dct_pkg::DCT_DATA_W-1:0]   reg_rdata,
    output logic [7:0]                       bus_in,
    output logic                             unit_selected_flag,
    output logic                             write_gate,
    output logic                             read_gate,
    output logic                             mark_write,
    output logic                             write_fault_inhibit,
    output logic                             mark_search,
    output logic                             diag_request,
    output logic                             seek_end,
    output logic                             seek_failed,
    output logic                             irq
);
    import dct_pkg::*;

    logic                rst_s1;
    logic                rstn_q;
    dct_sel_t            sel_state;
    dct_sel_t            next_sel_state;
    logic [UNIT_W-1:0]   sel_addr;
    logic [UNIT_W-1:0]   plug_reg;
    logic                mark_found;
    logic [DCT_EV_W-1:0] ev_status;
    logic [DCT_EV_W-1:0] ev_mask;
    logic                check_q;

    // Reset is released through two flops so removal is clean
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1 <= 1'b0;
            rstn_q <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rstn_q <= rst_s1;
        end
    end

    // Address compare and command decode
    wire addr_match = (sel_addr == plug_reg);
    wire selected   = (sel_state == DCT_SEL);
    wire ctl_cmd    = selected && (tag == DCT_TAG_CONTROL);
    wire diag_cmd   = selected && (tag == DCT_TAG_DIAG);
    wire wr_req     = ctl_cmd && bus_out[DCT_BO_WRITE];
    wire rd_req     = ctl_cmd && bus_out[DCT_BO_READ];
    wire mk_req     = ctl_cmd && bus_out[DCT_BO_MARK];
    wire search_on  = mk_req && rd_req;
    wire mark_hit   = search_on && mark_detect;
    // Check summary: seek error, fault, no head, or a write while write protected
    wire check_now  = seek_error_latch || fault_latch || no_head_fault
                      || (wr_req && write_protect);
    wire ready_now  = spindle_up && heads_loaded && !fault_cond;

    // Inbound byte built from live state, quiet when not selected
    wire [7:0] bus_in_next = selected ? {
        check_now,
        servo_offset,
        2'b00,
        ready_now,
        heads_positioned,
        1'b0,
        mark_found || mark_hit
    } : DCT_BUS_RST;

    // Selection: strobe captures, next cycle compares
    always_comb begin
        next_sel_state = sel_state;
        case (sel_state)
            DCT_IDLE:    if (select_strobe) next_sel_state = DCT_COMPARE;
            DCT_COMPARE: next_sel_state = addr_match ? DCT_SEL : DCT_IDLE;
            DCT_SEL:     if (select_strobe) next_sel_state = DCT_COMPARE;
            default:     next_sel_state = DCT_IDLE;
        endcase
    end

    // Both addresses captured together so a plug change mid-session waits
    always_ff @(posedge clk or negedge rstn_q) begin
        if (!rstn_q) begin
            sel_state <= DCT_IDLE;
            sel_addr  <= '0;
            plug_reg  <= '0;
        end else begin
            sel_state <= next_sel_state;
            if (select_strobe) begin
                sel_addr <= unit_addr;
                plug_reg <= plug_addr;
            end
        end
    end

    // Mark stays found until the search is dropped
    always_ff @(posedge clk or negedge rstn_q) begin
        if (!rstn_q)
            mark_found <= 1'b0;
        else
            mark_found <= search_on && (mark_found || mark_detect);
    end

    // Drive-facing outputs registered; gates follow the held control tag
    always_ff @(posedge clk or negedge rstn_q) begin
        if (!rstn_q) begin
            bus_in              <= DCT_BUS_RST;
            unit_selected_flag  <= 1'b0;
            write_gate          <= 1'b0;
            read_gate           <= 1'b0;
            mark_write          <= 1'b0;
            write_fault_inhibit <= 1'b0;
            mark_search         <= 1'b0;
            diag_request        <= 1'b0;
        end else begin
            bus_in              <= bus_in_next;
            unit_selected_flag  <= selected;
            write_gate          <= wr_req;
            read_gate           <= rd_req;
            mark_write          <= mk_req && wr_req;
            write_fault_inhibit <= mk_req && wr_req;
            mark_search         <= search_on;
            diag_request        <= diag_cmd;
        end
    end

    // Seek end report: pulse plus outcome held until the next end
    always_ff @(posedge clk or negedge rstn_q) begin
        if (!rstn_q) begin
            seek_end    <= 1'b0;
            seek_failed <= 1'b0;
        end else begin
            seek_end <= seek_done;
            if (seek_done)
                seek_failed <= !seek_ok;
        end
    end

    // Event sources; summary bit raises an event on its rising edge
    wire [DCT_EV_W-1:0] ev_set = {
        check_now && !check_q,
        seek_done && !seek_ok,
        seek_done && seek_ok,
        mark_hit && !mark_found
    };
    wire wr_status = reg_wr && (reg_addr == DCT_REG_STATUS);
    wire wr_mask   = reg_wr && (reg_addr == DCT_REG_MASK);
    wire [DCT_EV_W-1:0] w1c = wr_status ? reg_wdata[DCT_EV_W-1:0] : '0;
    // Set beats clear so an event in the clearing cycle survives
    wire [DCT_EV_W-1:0] next_status = (ev_status & ~w1c) | ev_set;

    // Readback select; unmapped words read zero
    wire [DCT_DATA_W-1:0] rd_mux =
        (reg_addr == DCT_REG_STATUS) ? {4'h0, ev_status} :
        (reg_addr == DCT_REG_MASK)   ? {4'h0, ev_mask} :
        (reg_addr == DCT_REG_STATE)  ? {2'b00, seek_failed, mark_found,
                                        mark_search, read_gate, write_gate,
                                        unit_selected_flag} :
        8'h00;

    // Register file, interrupt and read data
    always_ff @(posedge clk or negedge rstn_q) begin
        if (!rstn_q) begin
            ev_status <= '0;
            ev_mask   <= DCT_MASK_RST;
            check_q   <= 1'b0;
            irq       <= 1'b0;
            reg_rdata <= '0;
        end else begin
            ev_status <= next_status;
            check_q   <= check_now;
            if (wr_mask)
                ev_mask <= reg_wdata[DCT_EV_W-1:0];
            irq       <= |(next_status & (wr_mask ?
                          reg_wdata[DCT_EV_W-1:0] : ev_mask));
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
        end
    end

    // Checks on the registered behaviour
    sequence strobe_match_s;
        select_strobe && (unit_addr == plug_addr);
    endsequence
    sequence ctl_write_s;
        ctl_cmd && bus_out[DCT_BO_WRITE];
    endsequence

    sel_after_match_a: assert property (@(posedge clk) disable iff (!rstn_q)
        strobe_match_s ##1 !select_strobe |=> ##1 unit_selected_flag)
        else $error("match did not select the unit");
    sel_mismatch_a: assert property (@(posedge clk) disable iff (!rstn_q)
        select_strobe && (unit_addr != plug_addr) |=> ##1 !unit_selected_flag)
        else $error("mismatch left the unit selected");
    quiet_unsel_a: assert property (@(posedge clk) disable iff (!rstn_q)
        !selected |=> (bus_in == 8'h00) && !write_gate && !read_gate)
        else $error("drivers active while unselected");
    write_gate_a: assert property (@(posedge clk) disable iff (!rstn_q)
        ctl_write_s |=> write_gate)
        else $error("write gate missing");
    read_gate_a: assert property (@(posedge clk) disable iff (!rstn_q)
        rd_req |=> read_gate && bus_in[DCT_BI_ONCYL] == $past(heads_positioned))
        else $error("read gate or on-cylinder wrong");
    mark_write_a: assert property (@(posedge clk) disable iff (!rstn_q)
        ctl_write_s and mk_req |=> mark_write && write_fault_inhibit)
        else $error("mark write not started");
    mark_found_a: assert property (@(posedge clk) disable iff (!rstn_q)
        search_on && mark_detect ##1 search_on |=> bus_in[DCT_BI_MARK])
        else $error("found mark not reported");
    check_sum_a: assert property (@(posedge clk) disable iff (!rstn_q)
        selected && (seek_error_latch || fault_latch) |=> bus_in[DCT_BI_CHECK])
        else $error("check summary missing");
    ready_a: assert property (@(posedge clk) disable iff (!rstn_q)
        selected && fault_cond |=> !bus_in[DCT_BI_READY] &&
        bus_in[DCT_BI_OFFSET] == $past(servo_offset))
        else $error("ready or offset wrong");
    seek_rep_a: assert property (@(posedge clk) disable iff (!rstn_q)
        seek_done && !seek_ok |=> seek_end && seek_failed ##1 !seek_end)
        else $error("seek error not reported");
    diag_a: assert property (@(posedge clk) disable iff (!rstn_q)
        diag_cmd |=> diag_request)
        else $error("diagnostic tag not decoded");

    // Status lines, capture path and register side, checked cycle by cycle
    sequence compare_hit_s;
        (sel_state == DCT_COMPARE) && addr_match;
    endsequence
    sequence compare_miss_s;
        (sel_state == DCT_COMPARE) && !addr_match;
    endsequence

    oncyl_line_a: assert property (
        @(posedge clk) disable iff (!rstn_q)
        selected |=> bus_in[DCT_BI_ONCYL] == $past(heads_positioned))
        else $error("on-cylinder line wrong");
    offset_line_a: assert property (
        @(posedge clk) disable iff (!rstn_q)
        selected |=> bus_in[DCT_BI_OFFSET] == $past(servo_offset))
        else $error("offset line wrong");
    ready_line_a: assert property (
        @(posedge clk) disable iff (!rstn_q)
        selected && spindle_up && heads_loaded && !fault_cond
        |=> bus_in[DCT_BI_READY])
        else $error("ready line missing");
    unit_capture_a: assert property (
        @(posedge clk) disable iff (!rstn_q)
        select_strobe |=> sel_addr == $past(unit_addr))
        else $error("unit address not captured");
    plug_capture_a: assert property (
        @(posedge clk) disable iff (!rstn_q)
        select_strobe |=> plug_reg == $past(plug_addr))
        else $error("plug address not captured");
    compare_hit_a: assert property (
        @(posedge clk) disable iff (!rstn_q)
        compare_hit_s |=> selected)
        else $error("equal addresses did not select");
    compare_miss_a: assert property (
        @(posedge clk) disable iff (!rstn_q)
        compare_miss_s |=> !selected)
        else $error("unequal addresses selected the unit");
    sel_flag_a: assert property (
        @(posedge clk) disable iff (!rstn_q)
        selected |=> unit_selected_flag)
        else $error("selected flag not raised");
    ignore_tag_a: assert property (
        @(posedge clk) disable iff (!rstn_q)
        !selected |=> !mark_search && !mark_write && !diag_request)
        else $error("tag decoded while unselected");
    mark_off_a: assert property (
        @(posedge clk) disable iff (!rstn_q)
        !(mk_req && wr_req) |=> !mark_write && !write_fault_inhibit)
        else $error("mark write without both bits");
    seek_ok_ev_a: assert property (
        @(posedge clk) disable iff (!rstn_q)
        seek_done && seek_ok |=> ev_status[DCT_EV_SEEK_OK])
        else $error("seek success event lost");
    irq_level_a: assert property (
        @(posedge clk) disable iff (!rstn_q)
        irq == |(ev_status & ev_mask))
        else $error("interrupt level wrong");
endmodule

// File: rtl/dct_pkg.sv
// Shared constants for the drive control-tag decoder
package dct_pkg;
    // Tag codes on the three tag lines
    localparam logic [2:0] DCT_TAG_DIAG    = 3'h2;
    localparam logic [2:0] DCT_TAG_CONTROL = 3'h7;
    // Outbound line indices for the control tag
    localparam int DCT_BO_WRITE   = 1;
    localparam int DCT_BO_READ    = 3;
    localparam int DCT_BO_MARK    = 4;
    // Inbound line indices
    localparam int DCT_BI_MARK    = 0;
    localparam int DCT_BI_ONCYL   = 2;
    localparam int DCT_BI_READY   = 3;
    localparam int DCT_BI_OFFSET  = 6;
    localparam int DCT_BI_CHECK   = 7;
    // Register word indices
    localparam logic [3:0] DCT_REG_STATUS = 4'h0;
    localparam logic [3:0] DCT_REG_MASK   = 4'h1;
    localparam logic [3:0] DCT_REG_STATE  = 4'h2;
    // Event bit positions in status and mask
    localparam int DCT_EV_MARK    = 0;
    localparam int DCT_EV_SEEK_OK = 1;
    localparam int DCT_EV_SEEK_ER = 2;
    localparam int DCT_EV_CHECK   = 3;
    localparam int DCT_EV_W       = 4;
    // Reset values
    localparam logic [3:0] DCT_MASK_RST   = 4'h0;
    localparam logic [7:0] DCT_BUS_RST    = 8'h00;
    // Widths
    localparam int DCT_ADDR_W     = 4;
    localparam int DCT_DATA_W     = 8;
    // Select path states
    typedef enum logic [1:0] {
        DCT_IDLE    = 2'b00,
        DCT_COMPARE = 2'b01,
        DCT_SEL     = 2'b10
    } dct_sel_t;
endpackage

// File: tb/dct_ctl_model.sv
// Controller-side model: drives select, tag and outbound lines
`timescale 1ns/1ps
module dct_ctl_model
    import dct_pkg::*;
(
    input  wire logic       clk,
    input  wire logic [7:0] bus_in,
    output logic [2:0]      tag,
    output logic [7:0]      bus_out,
    output logic            select_strobe,
    output logic [3:0]      unit_addr
);
    // Idle lines at time zero
    initial begin
        tag           = 3'h0;
        bus_out       = 8'h5a;
        select_strobe = 1'b0;
        unit_addr     = 4'h0;
    end

    // Select comes before any tag sequence; address held past the strobe
    task automatic sel(input logic [3:0] a);
        @(posedge clk);
        unit_addr     <= a;
        select_strobe <= 1'b1;
        @(posedge clk);
        select_strobe <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    // Read or write waits for on-cylinder, bounded so a refusal test ends
    task automatic cmd(input logic [2:0] t, input logic [7:0] b);
        int n;
        n = 0;
        while (t == DCT_TAG_CONTROL && (b[DCT_BO_WRITE] || b[DCT_BO_READ])
               && bus_in[DCT_BI_ONCYL] !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        @(posedge clk);
        tag     <= t;
        bus_out <= b;
    endtask

    // Released outbound lines show junk, never the last byte
    task automatic idle();
        @(posedge clk);
        tag     <= 3'h0;
        bus_out <= ~bus_out;
    endtask
endmodule

// File: tb/drive_control_tag_status_tb.sv
// Self-checking bench for the control-tag decoder and unit select
`timescale 1ns/1ps
module drive_control_tag_status_tb;
    import dct_pkg::*;
    logic       clk, rstn, select_strobe, seek_done, seek_ok;
    logic       reg_wr, reg_rd, irq, unit_selected_flag, diag_request;
    logic       write_gate, read_gate, mark_write, write_fault_inhibit;
    logic       mark_search, seek_end, seek_failed;
    logic [2:0] tag;
    logic [3:0] unit_addr, plug, reg_addr;
    logic [7:0] bus_out, bus_in, reg_wdata, reg_rdata, v;
    logic [9:0] st;
    logic [4:0] gates;
    int         miscompares, check_count;
    // Gate and status stimulus tables with expected results
    logic [7:0] gbo [5] = '{8'h02, 8'h08, 8'h12, 8'h18, 8'h20};
    logic [4:0] gex [5] = '{5'h10, 5'h08, 5'h16, 5'h09, 5'h00};
    logic [9:0] sst [8] = '{10'h100, 10'h0c0, 10'h0e0, 10'h010,
                            10'h008, 10'h004, 10'h002, 10'h001};
    logic [7:0] sex [8] = '{8'h04, 8'h08, 8'h00, 8'h40,
                            8'h80, 8'h80, 8'h80, 8'h00};

    assign gates = {write_gate, read_gate, mark_write, write_fault_inhibit,
                    mark_search};

    dct_ctl_model u_ctl (.clk(clk), .bus_in(bus_in), .tag(tag),
        .bus_out(bus_out), .select_strobe(select_strobe),
        .unit_addr(unit_addr));

    dct_drive_tag DUT (.clk(clk), .rstn(rstn), .tag(tag), .bus_out(bus_out),
        .select_strobe(select_strobe), .unit_addr(unit_addr),
        .plug_addr(plug), .mark_detect(st[9]), .heads_positioned(st[8]),
        .spindle_up(st[7]), .heads_loaded(st[6]), .fault_cond(st[5]),
        .servo_offset(st[4]), .seek_error_latch(st[3]),
        .fault_latch(st[2]), .no_head_fault(st[1]), .write_protect(st[0]),
        .seek_done(seek_done), .seek_ok(seek_ok), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .bus_in(bus_in),
        .unit_selected_flag(unit_selected_flag), .write_gate(write_gate),
        .read_gate(read_gate), .mark_write(mark_write),
        .write_fault_inhibit(write_fault_inhibit),
        .mark_search(mark_search), .diag_request(diag_request),
        .seek_end(seek_end), .seek_failed(seek_failed), .irq(irq));

    always #50 clk = ~clk;

    // Single compare point; every mismatch is reported and counted
    task automatic chk(input string n, input logic [7:0] s, e);
        check_count++;
        if (s !== e) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic setst(input logic [9:0] s);
        @(posedge clk);
        st <= s;
    endtask

    // Register bus: one-cycle strobes, read data in the following cycle
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask

    // Seek end pulse; the result shows one cycle after the input pulse
    task automatic seek(input logic ok);
        @(posedge clk);
        seek_done <= 1'b1;
        seek_ok   <= ok;
        @(posedge clk);
        seek_done <= 1'b0;
        @(negedge clk);
        chk("seek_end", seek_end, 8'h01);
        settle();
        chk("seek_failed", seek_failed, {7'h0, ~ok});
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Watchdog sized well beyond the few hundred cycles the tests need
    initial begin
        repeat (3000) @(posedge clk);
        miscompares++;
        close_out();
    end

    initial begin
        clk = 0; rstn = 0; plug = 4'h9; st = 0; seek_done = 0;
        seek_ok = 0; reg_addr = 0; reg_wdata = 0; reg_wr = 0; reg_rd = 0;
        miscompares = 0; check_count = 0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        settle();
        chk("flag_rst", unit_selected_flag, 8'h00);
        rd(DCT_REG_MASK, v);
        chk("mask_rst", v, DCT_MASK_RST);
        // Commands before select must be ignored
        setst(10'h100);
        u_ctl.cmd(DCT_TAG_CONTROL, 8'h02);
        settle();
        chk("gates_unsel", gates, 8'h00);
        chk("bus_in_unsel", bus_in, 8'h00);
        u_ctl.idle();
        $display("test unselected done");
        // Wrong address, then matching address, then plug changes after
        u_ctl.sel(4'h3);
        @(negedge clk);
        chk("flag_miss", unit_selected_flag, 8'h00);
        u_ctl.sel(4'h9);
        plug <= 4'h3;
        settle();
        chk("flag_hit", unit_selected_flag, 8'h01);
        $display("test select done");
        // Write and read bits on their own, the mark combinations, then an unused bit
        for (int i = 0; i < 5; i++) begin
            u_ctl.cmd(DCT_TAG_CONTROL, gbo[i]);
            settle();
            chk("gates", gates, gex[i]);
            chk("bus_in_cyl", bus_in, 8'h04);
        end
        setst(10'h300);
        u_ctl.cmd(DCT_TAG_CONTROL, 8'h18);
        settle();
        chk("mark_found", bus_in, 8'h05);
        setst(10'h101);
        u_ctl.cmd(DCT_TAG_CONTROL, 8'h02);
        settle();
        chk("check_wp", bus_in, 8'h84);
        u_ctl.cmd(3'h6, 8'h02);
        settle();
        chk("gates_other", gates, 8'h00);
        u_ctl.idle();
        $display("test control done");
        // Inbound status lines one by one
        for (int i = 0; i < 8; i++) begin
            setst(sst[i]);
            settle();
            chk("bus_in_st", bus_in, sex[i]);
        end
        u_ctl.cmd(DCT_TAG_DIAG, 8'h00);
        settle();
        chk("diag", diag_request, 8'h01);
        u_ctl.idle();
        setst(10'h000);
        settle();
        chk("diag_off", diag_request, 8'h00);
        $display("test status done");
        // Events, mask, clear and interrupt
        wr(DCT_REG_STATUS, 8'h0f);
        rd(DCT_REG_STATUS, v);
        chk("st_clear", v, 8'h00);
        chk("irq_idle", irq, 8'h00);
        wr(DCT_REG_MASK, 8'h02);
        seek(1'b1);
        chk("irq_ok", irq, 8'h01);
        rd(DCT_REG_STATUS, v);
        chk("st_ok", v, 8'h02);
        seek(1'b0);
        rd(DCT_REG_STATUS, v);
        chk("st_err", v, 8'h06);
        wr(DCT_REG_STATUS, 8'h02);
        settle();
        chk("irq_masked", irq, 8'h00);
        rd(DCT_REG_STATE, v);
        chk("state", v, 8'h21);
        wr(4'h5, 8'hff);
        rd(4'h5, v);
        chk("unmapped", v, 8'h00);
        rd(DCT_REG_MASK, v);
        chk("mask_kept", v, 8'h02);
        $display("test registers done");
        // Losing select silences decode and inbound drivers
        u_ctl.sel(4'h9);
        setst(10'h100);
        u_ctl.cmd(DCT_TAG_CONTROL, 8'h02);
        settle();
        chk("flag_lost", unit_selected_flag, 8'h00);
        chk("gates_lost", gates, 8'h00);
        chk("bus_in_lost", bus_in, 8'h00);
        $display("test deselect done");
        close_out();
    end
endmodule
